// ### src/cssc_regs.svh
`ifndef CSSC_REGS_SVH
`define CSSC_REGS_SVH
// Register byte addresses
`define CSSC_OSC_CTRL_ADDR 12'h000
`define CSSC_CFG_ADDR 12'h004
`define CSSC_PWR_ADDR 12'h008
`define CSSC_STAT_ADDR 12'h00c
`define CSSC_UNLOCK_ADDR 12'h010
// Oscillator control register fields
`define CSSC_CUR_LSB 12
`define CSSC_NEW_LSB 8
`define CSSC_LOCK_BIT 5
`define CSSC_FAIL_BIT 3
`define CSSC_SECEN_BIT 1
`define CSSC_REQ_BIT 0
// Configuration register fields
`define CSSC_CFG_SWEN_BIT 0
`define CSSC_CFG_INIT_LSB 4
`define CSSC_CFG_SUBM_LSB 8
`define CSSC_CFG_RESET 32'h0000_0001
// Power register fields
`define CSSC_PWR_DEEP_SLEEP_ENABLE_BIT 0
`define CSSC_PWR_SLEEP_CMD 8'h00
`define CSSC_PWR_IDLE_CMD 8'h01
`define CSSC_PWR_CMD_LSB 8
// Unlock keys: high byte pair and low byte pair
`define CSSC_KEY_HI1 32'h0000_0078
`define CSSC_KEY_HI2 32'h0000_009a
`define CSSC_KEY_LO1 32'h0000_0046
`define CSSC_KEY_LO2 32'h0000_0057
// Timing
`define CSSC_SETTLE_CYCLES 10
`define CSSC_OST_CYCLES 1024
`endif

// ### src/cssc_pkg.sv
package cssc_pkg;
   typedef enum logic [2:0] {
      CSSC_SRC_FRC = 3'h0,
      CSSC_SRC_FAST_RC_WITH_PLL_SEL = 3'h1,
      CSSC_SRC_PRI = 3'h2,
      CSSC_SRC_PRIPLL = 3'h3,
      CSSC_SRC_SEC = 3'h4,
      CSSC_SRC_LOW_POWER_RC_OSC = 3'h5,
      CSSC_SRC_RSV6 = 3'h6,
      CSSC_SRC_RSV7 = 3'h7
   } cssc_src_t;
   typedef enum logic [5:0] {
      CSSC_ST_RUN = 6'h01,
      CSSC_ST_CHECK = 6'h02,
      CSSC_ST_START = 6'h04,
      CSSC_ST_SETTLE = 6'h08,
      CSSC_ST_SLEEP = 6'h10,
      CSSC_ST_IDLE = 6'h20
   } cssc_state_t;
   // Oscillator enables travel together
   typedef struct packed {
      logic fast_rc_osc;
      logic primary_osc;
      logic secondary_osc;
      logic low_power_rc_osc;
      logic pll;
   } cssc_osc_en_t;
   // Power mode outputs
   typedef struct packed {
      logic cpu_halt;
      logic sysclk_gate;
      logic periph_halt;
      logic pins_frozen;
      logic mem_power_off;
      logic wdt_clear;
   } cssc_pwr_t;
endpackage

// ### src/cssc_unlock.sv
`timescale 1ns/1ps
`include "cssc_regs.svh"
// Two-key unlock: opens a single-access window to one byte of the control reg
module cssc_unlock (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Key writes and the consuming access
   input wire logic key_wr,
   input wire logic [31:0] key_data,
   input wire logic ctrl_wr,
   // Window state
   output logic hi_open,
   output logic lo_open
);
   logic [1:0] stage_ff;
   logic hi_sel_ff;
   logic hi_open_ff;
   logic lo_open_ff;
   wire first_hi = key_wr && key_data == `CSSC_KEY_HI1;
   wire first_lo = key_wr && key_data == `CSSC_KEY_LO1;
   wire second_ok = key_wr && stage_ff == 2'h1 &&
                    key_data == (hi_sel_ff ? `CSSC_KEY_HI2 : `CSSC_KEY_LO2);
   // Any control write closes both windows after it is used
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stage_ff <= 2'h0;
         hi_sel_ff <= 1'b0;
         hi_open_ff <= 1'b0;
         lo_open_ff <= 1'b0;
      end else if (ctrl_wr) begin
         stage_ff <= 2'h0;
         hi_open_ff <= 1'b0; // [RULE23]
         lo_open_ff <= 1'b0;
      end else if (second_ok) begin
         stage_ff <= 2'h0;
         hi_open_ff <= hi_sel_ff; // [RULE23]
         lo_open_ff <= !hi_sel_ff;
      end else if (first_hi || first_lo) begin
         stage_ff <= 2'h1;
         hi_sel_ff <= first_hi;
         hi_open_ff <= 1'b0;
         lo_open_ff <= 1'b0;
      end else if (key_wr) begin
         stage_ff <= 2'h0; // A wrong key aborts the sequence
      end
   end
   assign hi_open = hi_open_ff;
   assign lo_open = lo_open_ff;
endmodule // cssc_unlock

// ### src/cssc_settle.sv
`timescale 1ns/1ps
// Counts edges of the new clock (sampled as a level) once the source is ready
module cssc_settle #(
   parameter int COUNT = 10
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Control
   input wire logic run,
   input wire logic new_clk_tick,
   // Result
   output logic done
);
   localparam int W = $clog2(COUNT + 1);
   logic [W-1:0] cnt_ff;
   logic done_ff;
   initial begin
      if (COUNT < 1) $error("COUNT must be at least 1");
   end
   // Counter restarts whenever run drops, so an aborted switch leaves no residue
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= '0;
         done_ff <= 1'b0;
      end else if (!run) begin
         cnt_ff <= '0;
         done_ff <= 1'b0;
      end else if (new_clk_tick && !done_ff) begin
         cnt_ff <= cnt_ff + W'(1);
         done_ff <= (cnt_ff == W'(COUNT - 1)); // [RULE8]
      end
   end
   assign done = done_ff;
endmodule // cssc_settle

// ### src/cssc_top.sv
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "cssc_regs.svh"
// Function
// RULE1 - Switching and clock monitor work only when switch-enable config bit is 0
// RULE2 - With switching off, new-source ignored; current-source shows initial config
// RULE3 - With switching off, switch-request does nothing and reads 0
// RULE4 - Software unlocks high byte, writes new source, unlocks low byte, sets request
// RULE5 - Equal current and new source: request cleared, switch abandoned
// RULE6 - Valid switch start clears PLL lock and clock-fail flags
// RULE7 - Start new oscillator; wait startup timer for crystal, lock for PLL
// RULE8 - Count ten new-clock cycles before the change-over
// RULE9 - On completion clear request and copy new source into current source
// RULE10 - Old source off, except low-power RC in use or secondary enabled
// RULE11 - CPU keeps running throughout the switch
// RULE12 - Software never switches directly between the two PLL sources
// RULE13 - Primary submode fixed by config, not by switching
// RULE14 - Sleep stops clocks and code; Idle halts CPU, peripherals run
// RULE15 - Deep Sleep stops all but calendar and its watchdog, freezes pins, memory off
// RULE16 - Sleep shuts the system source, on-chip oscillator, freezes pins
// RULE17 - Clock-fail monitor inactive in Sleep
// RULE18 - Low-power RC runs in Sleep when watchdog or calendar uses it
// RULE19 - Watchdog count cleared just before Sleep
// RULE20 - System-clock peripherals off in Sleep; pin change and external-clock ones run
// RULE21 - Wake from Sleep or Idle on enabled interrupt, reset or watchdog time-out
// RULE22 - Wake from Sleep on the same clock source as before
// RULE23 - Two-key unlock opens one access to the targeted control byte
module cssc_top
   import cssc_pkg::*;
#(
   parameter int OST_CYCLES = `CSSC_OST_CYCLES,
   parameter int SETTLE_CYCLES = `CSSC_SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Oscillator side
   input wire logic pll_locked,
   input wire logic new_clk_tick,
   input wire logic clock_fail_detect,
   input wire logic wdt_uses_low_power_rc_osc,
   input wire logic rtc_uses_low_power_rc_osc,
   input wire logic wdt_enabled,
   // Wake events
   input wire logic irq_wake,
   input wire logic wdt_timeout,
   // Clock controls
   output cssc_osc_en_t osc_en,
   output logic [2:0] sysclk_sel,
   output logic [2:0] primary_submode,
   output logic fail_monitor_en,
   // Power state
   output cssc_pwr_t pwr
);
   localparam int OW = $clog2(OST_CYCLES + 1);
   initial begin
      if (OST_CYCLES < 1) $error("OST_CYCLES must be at least 1");
   end
   cssc_state_t st_ff, nxt_st;
   logic [31:0] cfg_ff;
   logic [2:0] cur_ff, new_ff;
   logic req_ff, lock_ff, fail_ff, secen_ff, deep_sleep_enable_ff, sleep_deep_ff;
   logic [OW-1:0] ost_ff;
   logic [11:0] a_ff;
   logic w_ff, act_ff;
   cssc_osc_en_t osc_en_ff;
   cssc_pwr_t pwr_ff;
   logic [31:0] rdata_ff;
   logic [2:0] sel_ff;

   // Address phase capture
   wire take = hsel && hready && htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_ff <= 12'h000;
         w_ff <= 1'b0;
         act_ff <= 1'b0;
      end else if (hready) begin
         a_ff <= haddr[11:0];
         w_ff <= hwrite;
         act_ff <= take;
      end
   end

   // Data phase decode
   wire wr = act_ff && w_ff;
   wire wr_ctrl = wr && a_ff == `CSSC_OSC_CTRL_ADDR;
   wire wr_cfg = wr && a_ff == `CSSC_CFG_ADDR;
   wire wr_pwr = wr && a_ff == `CSSC_PWR_ADDR;
   wire wr_key = wr && a_ff == `CSSC_UNLOCK_ADDR;
   wire sw_en = !cfg_ff[`CSSC_CFG_SWEN_BIT]; // [RULE1]
   wire [2:0] init_src = cfg_ff[`CSSC_CFG_INIT_LSB +: 3];
   wire hi_open, lo_open;

   cssc_unlock u_unlock (
      .hclk(hclk),
      .hresetn(hresetn),
      .key_wr(wr_key),
      .key_data(hwdata),
      .ctrl_wr(wr_ctrl),
      .hi_open(hi_open),
      .lo_open(lo_open)
   );

   // Source class helpers
   function automatic logic is_pll(input logic [2:0] s);
      is_pll = (s == CSSC_SRC_FAST_RC_WITH_PLL_SEL) || (s == CSSC_SRC_PRIPLL);
   endfunction
   function automatic logic is_xtal(input logic [2:0] s);
      is_xtal = (s == CSSC_SRC_PRI) || (s == CSSC_SRC_PRIPLL) || (s == CSSC_SRC_SEC);
   endfunction
   function automatic cssc_osc_en_t src_en(input logic [2:0] s);
      src_en = '0;
      src_en.fast_rc_osc = (s == CSSC_SRC_FRC) || (s == CSSC_SRC_FAST_RC_WITH_PLL_SEL);
      src_en.primary_osc = (s == CSSC_SRC_PRI) || (s == CSSC_SRC_PRIPLL);
      src_en.secondary_osc = (s == CSSC_SRC_SEC);
      src_en.low_power_rc_osc = (s == CSSC_SRC_LOW_POWER_RC_OSC);
      src_en.pll = is_pll(s);
   endfunction

   wire set_req = wr_ctrl && lo_open && hwdata[`CSSC_REQ_BIT] && sw_en; // [RULE3]
   wire settle_done;
   wire ost_done = (ost_ff == OW'(0));
   wire ready_new = (!is_xtal(new_ff) || ost_done) && (!is_pll(new_ff) || pll_locked); // [RULE7]
   wire pwr_cmd = wr_pwr && hwdata[`CSSC_PWR_CMD_LSB +: 8] == `CSSC_PWR_SLEEP_CMD;
   wire idle_cmd = wr_pwr && hwdata[`CSSC_PWR_CMD_LSB +: 8] == `CSSC_PWR_IDLE_CMD;
   wire wake = irq_wake || wdt_timeout; // [RULE21]
   wire low_power_rc_osc_keep = wdt_uses_low_power_rc_osc || rtc_uses_low_power_rc_osc;

   cssc_settle #(.COUNT(SETTLE_CYCLES)) u_settle (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(st_ff == CSSC_ST_SETTLE),
      .new_clk_tick(new_clk_tick),
      .done(settle_done)
   );

   // Switch and power state machine; CPU never halted during a switch
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         CSSC_ST_RUN: begin
            if (req_ff) nxt_st = CSSC_ST_CHECK;
            else if (pwr_cmd) nxt_st = CSSC_ST_SLEEP; // [RULE14]
            else if (idle_cmd) nxt_st = CSSC_ST_IDLE; // [RULE14]
         end
         CSSC_ST_CHECK: nxt_st = (cur_ff == new_ff) ? CSSC_ST_RUN : CSSC_ST_START; // [RULE5]
         CSSC_ST_START: if (ready_new) nxt_st = CSSC_ST_SETTLE;
         CSSC_ST_SETTLE: if (settle_done) nxt_st = CSSC_ST_RUN; // [RULE8]
         CSSC_ST_SLEEP: if (wake) nxt_st = CSSC_ST_RUN; // [RULE21]
         CSSC_ST_IDLE: if (wake) nxt_st = CSSC_ST_RUN; // [RULE21]
         default: nxt_st = CSSC_ST_RUN;
      endcase
   end

   wire switch_start = (st_ff == CSSC_ST_CHECK) && (cur_ff != new_ff);
   wire switch_done = (st_ff == CSSC_ST_SETTLE) && settle_done;
   wire in_switch = (st_ff == CSSC_ST_START) || (st_ff == CSSC_ST_SETTLE);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) st_ff <= CSSC_ST_RUN;
      else st_ff <= nxt_st;
   end

   // Configuration word: writable by software, models the fuse word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cfg_ff <= `CSSC_CFG_RESET;
      else if (wr_cfg) cfg_ff <= hwdata;
   end

   // Control register fields
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_ff <= 3'h0;
         new_ff <= 3'h0;
         req_ff <= 1'b0;
         secen_ff <= 1'b0;
         deep_sleep_enable_ff <= 1'b0;
      end else begin
         if (!sw_en) cur_ff <= init_src; // [RULE2]
         else if (switch_done) cur_ff <= new_ff; // [RULE9]
         if (wr_ctrl && hi_open) new_ff <= hwdata[`CSSC_NEW_LSB +: 3];
         if (wr_ctrl && lo_open) secen_ff <= hwdata[`CSSC_SECEN_BIT];
         if (!sw_en) req_ff <= 1'b0; // [RULE3]
         else if (set_req) req_ff <= 1'b1;
         else if ((st_ff == CSSC_ST_CHECK && cur_ff == new_ff) || switch_done)
            req_ff <= 1'b0; // [RULE5] [RULE9]
         if (wr_pwr) deep_sleep_enable_ff <= hwdata[`CSSC_PWR_DEEP_SLEEP_ENABLE_BIT];
         else if (st_ff == CSSC_ST_SLEEP && wake) deep_sleep_enable_ff <= 1'b0;
      end
   end

   // Lock and fail flags: hardware set wins over switch-start clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_ff <= 1'b0;
         fail_ff <= 1'b0;
      end else begin
         if (pll_locked && is_pll(new_ff) && in_switch) lock_ff <= 1'b1;
         else if (switch_start) lock_ff <= 1'b0; // [RULE6]
         if (clock_fail_detect && fail_monitor_en) fail_ff <= 1'b1;
         else if (switch_start) fail_ff <= 1'b0; // [RULE6]
      end
   end

   // A crystal already running needs no start-up wait
   wire xtal_on = |(src_en(new_ff) & osc_en_ff & 5'h0c);
   // Startup timer reloads at switch start, runs only for crystal sources
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ost_ff <= OW'(0);
      else if (switch_start && is_xtal(new_ff) && !xtal_on)
         ost_ff <= OW'(OST_CYCLES); // [RULE7]
      else if (st_ff == CSSC_ST_START && !ost_done) ost_ff <= ost_ff - OW'(1);
   end

   // Oscillator enables; old source drops at change-over
   cssc_osc_en_t nxt_osc;
   always_comb begin
      nxt_osc = src_en(cur_ff);
      if (in_switch) nxt_osc = nxt_osc | src_en(new_ff); // [RULE7]
      nxt_osc.low_power_rc_osc = nxt_osc.low_power_rc_osc || low_power_rc_osc_keep; // [RULE10]
      nxt_osc.secondary_osc = nxt_osc.secondary_osc || secen_ff; // [RULE10]
      if (st_ff == CSSC_ST_SLEEP) begin
         nxt_osc = '0; // [RULE16]
         nxt_osc.low_power_rc_osc = low_power_rc_osc_keep; // [RULE18]
         nxt_osc.secondary_osc = secen_ff;
      end
   end

   // Power outputs; deep sleep chosen by the enable latched at sleep entry
   cssc_pwr_t nxt_pwr;
   wire sleeping = (nxt_st == CSSC_ST_SLEEP);
   // The enable may come in the same write as the sleep command
   wire deep_sleep_enable_now = wr_pwr ? hwdata[`CSSC_PWR_DEEP_SLEEP_ENABLE_BIT] : deep_sleep_enable_ff;
   wire deep = sleeping && (st_ff == CSSC_ST_SLEEP ? sleep_deep_ff : deep_sleep_enable_now);
   always_comb begin
      nxt_pwr = '0;
      nxt_pwr.cpu_halt = sleeping || nxt_st == CSSC_ST_IDLE; // [RULE11] [RULE14]
      nxt_pwr.sysclk_gate = sleeping; // [RULE16] [RULE20]
      nxt_pwr.periph_halt = sleeping; // [RULE20]
      nxt_pwr.pins_frozen = sleeping; // [RULE16] [RULE15]
      nxt_pwr.mem_power_off = deep; // [RULE15]
      nxt_pwr.wdt_clear = pwr_cmd && st_ff == CSSC_ST_RUN && !req_ff && wdt_enabled; // [RULE19]
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) sleep_deep_ff <= 1'b0;
      else if (st_ff != CSSC_ST_SLEEP) sleep_deep_ff <= deep_sleep_enable_now;
   end

   // Read mux decoded in the address phase; a read just behind a write sees old data
   wire [31:0] ctrl_rd = {17'h0, cur_ff, 1'b0, new_ff, 2'h0, lock_ff, 1'b0,
                          fail_ff, 1'b0, secen_ff, req_ff && sw_en}; // [RULE3]
   wire [31:0] stat_rd = {26'h0, st_ff};
   wire [31:0] rd_mux = (haddr[11:0] == `CSSC_OSC_CTRL_ADDR) ? ctrl_rd :
                        (haddr[11:0] == `CSSC_CFG_ADDR) ? cfg_ff :
                        (haddr[11:0] == `CSSC_PWR_ADDR) ? {31'h0, deep_sleep_enable_ff} :
                        (haddr[11:0] == `CSSC_STAT_ADDR) ? stat_rd : 32'h0;
   // Output registers; sysclk stays on cur_ff so Sleep wakes on the same source
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_en_ff <= '0;
         pwr_ff <= '0;
         rdata_ff <= 32'h0;
         sel_ff <= 3'h0;
      end else begin
         osc_en_ff <= nxt_osc;
         pwr_ff <= nxt_pwr;
         rdata_ff <= (take && !hwrite) ? rd_mux : 32'h0;
         sel_ff <= switch_done ? new_ff : cur_ff; // [RULE22] [RULE9]
      end
   end

   logic mon_ff;
   logic [2:0] subm_ff;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mon_ff <= 1'b0;
         subm_ff <= 3'h0;
      end else begin
         mon_ff <= sw_en && nxt_st != CSSC_ST_SLEEP; // [RULE1] [RULE17]
         subm_ff <= cfg_ff[`CSSC_CFG_SUBM_LSB +: 3]; // [RULE13]
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_ff;
   assign osc_en = osc_en_ff;
   assign sysclk_sel = sel_ff;
   assign primary_submode = subm_ff;
   assign fail_monitor_en = mon_ff;
   assign pwr = pwr_ff;
endmodule // cssc_top

// ### verification/cssc_top_chk.sv
`timescale 1ns/1ps
// Port-level checker for the clock switch and sleep controller
module cssc_top_chk
   import cssc_pkg::*;
#(
   parameter int OST_CYCLES = 1024,
   parameter int SETTLE_CYCLES = 10
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus side
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Oscillator side
   input wire logic pll_locked,
   input wire logic new_clk_tick,
   input wire logic clock_fail_detect,
   input wire logic wdt_uses_low_power_rc_osc,
   input wire logic rtc_uses_low_power_rc_osc,
   input wire logic wdt_enabled,
   input wire logic irq_wake,
   input wire logic wdt_timeout,
   // Controls
   input wire cssc_osc_en_t osc_en,
   input wire logic [2:0] sysclk_sel,
   input wire logic [2:0] primary_submode,
   input wire logic fail_monitor_en,
   input wire cssc_pwr_t pwr
);
   logic [7:0] tick_cnt_ff;
   wire ctrl_wr = hsel && hready && htrans[1] && hwrite && (haddr[11:0] == 12'h000);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // New-clock ticks since the last control write; a request always restarts it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_ff <= 8'h00;
      end else if (ctrl_wr) begin
         tick_cnt_ff <= 8'h00;
      end else if (new_clk_tick && tick_cnt_ff != 8'hff) begin
         tick_cnt_ff <= tick_cnt_ff + 8'h01;
      end
   end
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus stalled or errored");
   chk_swoff_hold: assert property (!fail_monitor_en |=> $stable(sysclk_sel))
      else $error("clock changed while switching off");
   chk_settle_count: assert property ($changed(sysclk_sel) |-> tick_cnt_ff >= SETTLE_CYCLES)
      else $error("change-over before settle count");
   chk_pll_lock: assert property ($changed(sysclk_sel) && sysclk_sel inside {3'h1, 3'h3}
      |-> $past(pll_locked)) else $error("pll source taken unlocked");
   chk_submode_fix: assert property ($changed(sysclk_sel) |-> $stable(primary_submode))
      else $error("submode moved by switch");
   chk_sleep_halt: assert property (pwr.sysclk_gate && $past(pwr.sysclk_gate)
      |-> pwr.cpu_halt && pwr.periph_halt) else $error("sleep left cpu or peripherals on");
   chk_sleep_mon: assert property (pwr.sysclk_gate && $past(pwr.sysclk_gate)
      |-> !fail_monitor_en) else $error("fail monitor on in sleep");
   chk_low_power_rc_osc_sleep: assert property (pwr.sysclk_gate && $past(pwr.sysclk_gate)
      && (wdt_uses_low_power_rc_osc || rtc_uses_low_power_rc_osc) |-> osc_en.low_power_rc_osc)
      else $error("low-power rc stopped in sleep");
   chk_wdt_pulse: assert property (pwr.wdt_clear |-> wdt_enabled ##1 !pwr.wdt_clear)
      else $error("bad watchdog clear pulse");
   chk_deep_mem: assert property (pwr.mem_power_off |-> pwr.pins_frozen && pwr.cpu_halt)
      else $error("deep sleep incomplete");
   chk_wake_event: assert property (pwr.cpu_halt && (irq_wake || wdt_timeout)
      |-> ##[1:4] !pwr.cpu_halt) else $error("no wake-up");
   chk_wake_source: assert property ($fell(pwr.cpu_halt) |-> $stable(sysclk_sel))
      else $error("wake on other source");
endmodule // cssc_top_chk

bind cssc_top cssc_top_chk #(.OST_CYCLES(OST_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES))
   cssc_top_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pll_locked(pll_locked),
   .new_clk_tick(new_clk_tick), .clock_fail_detect(clock_fail_detect),
   .wdt_uses_low_power_rc_osc(wdt_uses_low_power_rc_osc), .rtc_uses_low_power_rc_osc(rtc_uses_low_power_rc_osc), .wdt_enabled(wdt_enabled),
   .irq_wake(irq_wake), .wdt_timeout(wdt_timeout), .osc_en(osc_en), .sysclk_sel(sysclk_sel),
   .primary_submode(primary_submode), .fail_monitor_en(fail_monitor_en), .pwr(pwr));

// ### verification/cssc_osc_model.sv
`timescale 1ns/1ps
// Oscillator and PLL stand-in; slow stretches both lock time and tick rate
module cssc_osc_model
   import cssc_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // From the block, plus the slow-mode select from the testbench
   input wire cssc_osc_en_t osc_en,
   input wire logic slow,
   // To the block
   output logic pll_locked,
   output logic new_clk_tick
);
   logic [4:0] lock_cnt_ff;
   logic [1:0] div_ff;
   // Lock builds up while the PLL runs and is lost the moment it stops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_cnt_ff <= 5'h00;
         div_ff <= 2'h0;
      end else begin
         lock_cnt_ff <= !osc_en.pll ? 5'h00 : lock_cnt_ff + {4'h0, lock_cnt_ff != 5'h1f};
         div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
      end
   end
   assign pll_locked = lock_cnt_ff >= (slow ? 5'h14 : 5'h06);
   // Ticks while any oscillator is enabled, so only stopping them all stalls the count
   assign new_clk_tick = (|osc_en) && (!slow || div_ff == 2'h0);
endmodule // cssc_osc_model

// ### verification/cssc_top_tb_top.sv
`timescale 1ns/1ps
`include "cssc_regs.svh"
module cssc_top_tb_top
   import cssc_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, cfail, wdt_u, rtc_u, wdt_en, irq, wto, slow, seen_wclr;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, sysclk_sel, primary_submode;
   wire hready, hreadyout, hresp, pll_locked, new_clk_tick;
   wire [31:0] hrdata;
   logic fail_monitor_en;
   cssc_osc_en_t osc_en;
   cssc_pwr_t pwr;
   int n_fail = 0;
   int checked = 0;
   int seed = 11410;
   int cur_m = 0;
   logic [3:0] tbl [9] = '{4'h0, 4'h2, 4'h3, 4'h0, 4'h1, 4'h0, 4'hc, 4'hd, 4'h0};
   always #4 hclk = ~hclk;
   assign hready = hreadyout;
   // Short start-up timer keeps crystal switches quick
   cssc_top #(.OST_CYCLES(4), .SETTLE_CYCLES(10)) cssc_top_inst (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .pll_locked(pll_locked), .new_clk_tick(new_clk_tick),
      .clock_fail_detect(cfail), .wdt_uses_low_power_rc_osc(wdt_u), .rtc_uses_low_power_rc_osc(rtc_u),
      .wdt_enabled(wdt_en), .irq_wake(irq), .wdt_timeout(wto), .osc_en(osc_en),
      .sysclk_sel(sysclk_sel), .primary_submode(primary_submode),
      .fail_monitor_en(fail_monitor_en), .pwr(pwr));
   cssc_osc_model cssc_osc_model_inst (.hclk(hclk), .hresetn(hresetn), .osc_en(osc_en),
      .slow(slow), .pll_locked(pll_locked), .new_clk_tick(new_clk_tick));
   // The clear pulse lasts one cycle, so it is latched here
   always @(posedge hclk) if (pwr.wdt_clear === 1'b1) seen_wclr <= 1'b1;
   task end_sim;
      if (n_fail == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single-word transfer; read data lands in rd at the data-phase edge
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w; hsize <= 3'b010;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
      rd = hrdata;
      if (n >= 50) begin n_fail++; end_sim; end
   endtask
   task wait_halt(input logic v);
      int n;
      n = 0;
      while (pwr.cpu_halt !== v && n < 50) begin @(posedge hclk); n++; end
      if (n >= 50) begin n_fail++; end_sim; end
   endtask
   // Unlocked high-byte write of the new source, then unlocked request
   task sw(input logic [2:0] ns, input logic sec, input logic en);
      int n;
      int prev;
      prev = cur_m;
      n = 0;
      ahb(1, `CSSC_UNLOCK_ADDR, `CSSC_KEY_HI1); ahb(1, `CSSC_UNLOCK_ADDR, `CSSC_KEY_HI2);
      ahb(1, `CSSC_OSC_CTRL_ADDR, {21'h0, ns, 8'h00});
      ahb(1, `CSSC_UNLOCK_ADDR, `CSSC_KEY_LO1); ahb(1, `CSSC_UNLOCK_ADDR, `CSSC_KEY_LO2);
      ahb(1, `CSSC_OSC_CTRL_ADDR, {30'h0, sec, 1'b1});
      do begin ahb(0, `CSSC_OSC_CTRL_ADDR, 0); n++; end while (rd[0] !== 1'b0 && n < 100);
      if (n >= 100) begin n_fail++; end_sim; end
      if (en) cur_m = ns;
      repeat (2) @(posedge hclk);
      chk(32'(rd[14:12]), cur_m);
      chk(32'(sysclk_sel), cur_m);
      if (en && prev != ns) begin
         chk(32'(rd[3]), 0);
         if (ns inside {3'h1, 3'h3}) chk(32'(rd[5]), 1);
         if (prev inside {2, 3} && !(ns inside {2, 3})) chk(32'(osc_en.primary_osc), 0);
         if (prev < 2 && ns > 1) chk(32'(osc_en.fast_rc_osc), 0);
         if (prev == 4) chk(32'(osc_en.secondary_osc), 32'(sec));
      end
   endtask
   initial begin
      #400000;
      n_fail++;
      end_sim;
   end
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
      hsize = 3'b010; hwdata = 32'h0; cfail = 1'b0; wdt_u = 1'b0; rtc_u = 1'b0;
      wdt_en = 1'b0; irq = 1'b0; wto = 1'b0; slow = 1'b0; seen_wclr = 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(0, `CSSC_CFG_ADDR, 0); chk(rd, `CSSC_CFG_RESET);
      ahb(0, `CSSC_OSC_CTRL_ADDR, 0); chk(rd, 0);
      ahb(1, 32'h20, 32'($random(seed))); ahb(0, 32'h20, 0); chk(rd, 0);
      sw(3'h2, 1'b0, 1'b0);
      chk(32'(fail_monitor_en), 0);
      ahb(1, `CSSC_CFG_ADDR, 32'h0000_0200);
      repeat (2) @(posedge hclk);
      chk(32'(primary_submode), 2);
      chk(32'(fail_monitor_en), 1);
      // Second write after one unlock, and a low write with none, must both be ignored
      ahb(1, `CSSC_UNLOCK_ADDR, `CSSC_KEY_HI1); ahb(1, `CSSC_UNLOCK_ADDR, `CSSC_KEY_HI2);
      ahb(1, `CSSC_OSC_CTRL_ADDR, 32'h0000_0200); ahb(1, `CSSC_OSC_CTRL_ADDR, 32'h0000_0500);
      ahb(1, `CSSC_OSC_CTRL_ADDR, 32'h0000_0001); ahb(0, `CSSC_OSC_CTRL_ADDR, 0);
      chk(32'(rd[10:8]), 2);
      chk(32'(rd[0]), 0);
      cfail <= 1'b1; repeat (3) @(posedge hclk); cfail <= 1'b0;
      ahb(0, `CSSC_OSC_CTRL_ADDR, 0); chk(32'(rd[3]), 1);
      // PLL sources are always bridged through plain fast RC
      for (int i = 0; i < 9; i++) begin
         slow <= 1'(i % 2);
         sw(tbl[i][2:0], tbl[i][3], 1'b1);
      end
      // Sleep, idle, deep sleep in turn
      for (int k = 0; k < 3; k++) begin
         wdt_u <= 1'($random(seed)); rtc_u <= 1'($random(seed)); wdt_en <= 1'b1;
         seen_wclr = 1'b0;
         ahb(1, `CSSC_PWR_ADDR, (k == 1) ? 32'h0000_0100 : 32'(k / 2));
         wait_halt(1'b1); repeat (2) @(posedge hclk);
         chk(32'(pwr.sysclk_gate), 32'(k != 1));
         chk(32'(pwr.periph_halt), 32'(k != 1));
         chk(32'(pwr.pins_frozen), 32'(k != 1));
         chk(32'(pwr.mem_power_off), 32'(k == 2));
         chk(32'(fail_monitor_en), 32'(k == 1));
         if (k != 1) begin
            chk(32'(osc_en.fast_rc_osc), 0);
            chk(32'(seen_wclr), 1);
            if (wdt_u | rtc_u) chk(32'(osc_en.low_power_rc_osc), 1);
         end
         if (k == 1) wto <= 1'b1;
         else irq <= 1'b1;
         @(posedge hclk); wto <= 1'b0; irq <= 1'b0;
         wait_halt(1'b0); repeat (2) @(posedge hclk);
         chk(32'(sysclk_sel), cur_m);
         chk(32'(pwr.periph_halt), 0);
      end
      end_sim;
   end
endmodule // cssc_top_tb_top
